// file: tb.sv
// Self-checking bench for the parallel FIFO port with a host model.
// Assumes ufp_pkg, ufp_sync and ufp_port are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp); \
    end \
  end
module tb;
  logic       clock_i, rstn_i, rd_n, wr, rxf_lvl, rxf_o, rxf_oe, txe, txe_oe;
  logic       pwr_n, pdn, pup, cfg, susp, wake_en, pdn_en, rx_push_i, push_rdy;
  logic       tx_pop_valid_o, tx_pop_i, resume, bus_oe, oe_h, oe_a;
  logic [7:0] bus_lvl, bus_o, rx_push_data_i, tx_pop_data_o, d;
  int         n_fail, checks_done, cycles;
  // ==========================================================
  // Design and host
  ufp_port ufp_port_i (.clock_i(clock_i), .rstn_i(rstn_i), .rd_n_i(rd_n), .wr_i(wr),
    .fifo_byte_bus_i(bus_lvl), .fifo_byte_bus_o(bus_o), .fifo_byte_bus_oe_o(bus_oe),
    .rx_data_avail_n_i(rxf_lvl), .rx_data_avail_n_o(rxf_o), .rx_data_avail_n_oe_o(rxf_oe),
    .tx_space_avail_n_o(txe), .tx_space_avail_n_oe_o(txe_oe), .power_enable_n_o(pwr_n),
    .pull_down_o(pdn), .pull_up_o(pup), .usb_configured_i(cfg), .usb_suspend_i(susp),
    .remote_wake_en_i(wake_en), .suspend_pulldown_en_i(pdn_en), .rx_push_i(rx_push_i),
    .rx_push_data_i(rx_push_data_i), .rx_push_ready_o(push_rdy),
    .tx_pop_valid_o(tx_pop_valid_o), .tx_pop_data_o(tx_pop_data_o), .tx_pop_i(tx_pop_i),
    .resume_req_o(resume));
  ufp_host_model ufp_host_model_i (.clock_i(clock_i), .dev_bus_i(bus_o),
    .dev_bus_oe_i(bus_oe), .dev_rxf_i(rxf_o), .dev_rxf_oe_i(rxf_oe),
    .tx_space_avail_n_i(txe), .pull_down_i(pdn), .rd_n_o(rd_n), .wr_o(wr),
    .bus_o(bus_lvl), .rxf_o(rxf_lvl));
  // ==========================================================
  // Clock and hang guard; the full tx fill dominates the run time
  initial
  begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_fail++;
      results();
    end
  end
  task automatic results;
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Engine side: push into rx, pop from tx
  task automatic push_byte(input logic [7:0] v);
    @(posedge clock_i);
    rx_push_i <= 1'b1;
    rx_push_data_i <= v;
    @(negedge clock_i);
    while (push_rdy !== 1'b1) @(negedge clock_i);
    @(posedge clock_i);
    rx_push_i <= 1'b0;
  endtask
  task automatic pop_byte(output logic [7:0] v);
    @(negedge clock_i);
    while (tx_pop_valid_o !== 1'b1) @(negedge clock_i);
    @(posedge clock_i);
    tx_pop_i <= 1'b1;
    @(posedge clock_i);
    tx_pop_i <= 1'b0;
    @(posedge clock_i);
    @(negedge clock_i);
    v = tx_pop_data_o;
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    {rstn_i, cfg, susp, wake_en, pdn_en, rx_push_i, tx_pop_i} = 7'h00;
    rx_push_data_i = 8'h00;
    n_fail = 0;
    checks_done = 0;
    cycles = 0;
    repeat (12) @(posedge clock_i);
    @(negedge clock_i);
    `CHK(txe_oe, 1'b0)
    `CHK(rxf_oe, 1'b0)
    @(posedge clock_i);
    rstn_i <= 1'b1;
    cfg <= 1'b1;
    repeat (6) @(negedge clock_i);
    `CHK({pwr_n, txe, rxf_o, rxf_oe, pup}, 5'h07)
    ufp_host_model_i.read_byte(1'b1, d, oe_h, oe_a);
    `CHK(rxf_o, 1'b1)
    for (int i = 0; i < 3; i++) push_byte(8'hA0 + i[7:0]);
    repeat (2) @(negedge clock_i);
    `CHK(rxf_o, 1'b0)
    for (int i = 0; i < 3; i++)
    begin
      ufp_host_model_i.read_byte(1'b0, d, oe_h, oe_a);
      `CHK(d, 8'hA0 + i[7:0])
      `CHK({oe_h, oe_a}, 2'h2)
    end
    `CHK(rxf_o, 1'b1)
    // Fill the tx buffer with DEPTH bytes and check it reports full, then drain it in order
    for (int i = 0; i < ufp_pkg::DEPTH; i++) ufp_host_model_i.write_byte(i[7:0] ^ 8'h5A);
    repeat (8) @(negedge clock_i);
    `CHK(txe, 1'b1)
    for (int i = 0; i < ufp_pkg::DEPTH; i++)
    begin
      pop_byte(d);
      `CHK(d, i[7:0] ^ 8'h5A)
    end
    repeat (8) @(negedge clock_i);
    `CHK(txe, 1'b0)
    // Suspend with remote wake and weak pull-down
    @(posedge clock_i);
    susp <= 1'b1;
    wake_en <= 1'b1;
    pdn_en <= 1'b1;
    repeat (8) @(negedge clock_i);
    `CHK({pwr_n, rxf_oe, pdn}, 3'h5)
    ufp_host_model_i.wake_hold(200);
    @(negedge clock_i);
    `CHK(resume, 1'b0)
    @(posedge clock_i);
    pdn_en <= 1'b0;
    repeat (8) @(negedge clock_i);
    `CHK({pdn, pup}, 2'h1)
    @(posedge clock_i);
    susp <= 1'b0;
    repeat (8) @(negedge clock_i);
    `CHK({pwr_n, rxf_oe}, 2'h1)
    results();
  end
endmodule // tb
`default_nettype wire

// file: ufp_host_model.sv
// Host-side model of the parallel FIFO port: strobes, data bus and wake pin.
// Assumes the bench calls its tasks; pins change only at rising clock edges.
`timescale 1ns/1ps
`default_nettype none
module ufp_host_model
(
  // Clock
  input  wire logic       clock_i,
  // Device side of the pins
  input  wire logic [7:0] dev_bus_i,
  input  wire logic       dev_bus_oe_i,
  input  wire logic       dev_rxf_i,
  input  wire logic       dev_rxf_oe_i,
  input  wire logic       tx_space_avail_n_i,
  input  wire logic       pull_down_i,
  // Resolved pin levels
  output logic            rd_n_o,
  output logic            wr_o,
  output logic      [7:0] bus_o,
  output logic            rxf_o
);
  logic [7:0] host_data_r;
  logic       host_oe_r;
  logic       wake_low_r;
  // ==========================================================
  // Pin resolution; an undriven bus sits at the weak pull level
  assign bus_o = dev_bus_oe_i ? dev_bus_i : host_oe_r ? host_data_r : {8{~pull_down_i}};
  assign rxf_o = dev_rxf_oe_i ? dev_rxf_i : ~wake_low_r;
  initial
  begin
    rd_n_o = 1'b1;
    wr_o = 1'b0;
    host_data_r = 8'h00;
    host_oe_r = 1'b0;
    wake_low_r = 1'b0;
  end
  // ==========================================================
  // Byte write, only when space is reported
  task automatic write_byte(input logic [7:0] d);
    @(negedge clock_i);
    while (tx_space_avail_n_i !== 1'b0) @(negedge clock_i);
    @(posedge clock_i);
    host_data_r <= d;
    host_oe_r <= 1'b1;
    wr_o <= 1'b1;
    repeat (4) @(posedge clock_i);
    wr_o <= 1'b0;
    repeat (4) @(posedge clock_i);
    host_oe_r <= 1'b0;
  endtask
  // Byte read; ignore_flag reads an empty buffer on purpose
  task automatic read_byte(input bit ignore_flag, output logic [7:0] d,
                           output logic oe_held, output logic oe_after);
    @(negedge clock_i);
    while (!ignore_flag && rxf_o !== 1'b0) @(negedge clock_i);
    @(posedge clock_i);
    rd_n_o <= 1'b0;
    repeat (5) @(posedge clock_i);
    @(negedge clock_i);
    d = bus_o;
    oe_held = dev_bus_oe_i;
    @(posedge clock_i);
    rd_n_o <= 1'b1;
    repeat (4) @(posedge clock_i);
    @(negedge clock_i);
    oe_after = dev_bus_oe_i;
  endtask
  // Wake strobe on the flag pin, shorter than the wake interval
  task automatic wake_hold(input int n);
    @(posedge clock_i);
    wake_low_r <= 1'b1;
    repeat (n) @(posedge clock_i);
    wake_low_r <= 1'b0;
  endtask
endmodule // ufp_host_model
`default_nettype wire

// file: ufp_pkg.sv
// Package for the parallel FIFO host port: sizes, reset values, timing counts.
// Assumes a 20 MHz system clock; imported nowhere, used by scoped names.
package ufp_pkg;
  // ==========================================================
  // Sizes
  localparam int          BYTE_W       = 8;
  localparam int          DEPTH        = 512;
  localparam int          PTR_W        = 9;
  localparam int          CNT_W        = 10;
  // ==========================================================
  // Timing
  localparam int          CLK_NS       = 50;
  localparam int          WAKE_MS      = 20;
  localparam int          WAKE_CYCLES  = (WAKE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int          WAKE_CNT_W   = 20;
  // ==========================================================
  // Reset values
  localparam logic [7:0]  BYTE_RST     = 8'h00;
  localparam logic [8:0]  PTR_RST      = 9'h000;
  localparam logic [9:0]  CNT_RST      = 10'h000;
  localparam logic [19:0] WAKE_RST     = 20'h00000;
  // ==========================================================
  // Wake detector states
  typedef enum logic [1:0] {UFP_W_IDLE, UFP_W_COUNT, UFP_W_DONE} ufp_wake_t;
endpackage

// file: ufp_port.sv
// Parallel FIFO host port: strobe-driven byte exchange between USB buffers and host.
// Assumes the USB engine pushes rx bytes and pops tx bytes on clock_i; host pins async.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Drive receive byte onto data bus only while read strobe low.
// - Read strobe falling edge advances receive buffer if another byte exists.
// - Write strobe falling edge captures data bus into transmit buffer.
// - Receive-data flag low whenever bytes wait; host pulses read strobe.
// - Both flags tri-stated while device held in reset.
// - Remote wakeup enabled in suspend turns receive flag into input.
// - Host holds receive flag low 20 ms in suspend; device requests resume.
// - Optional weak pull-down of interface inputs during suspend.
// - Power-enable low once configured, high throughout suspend.
module ufp_port
(
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  // Host pins
  input  wire logic       rd_n_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] fifo_byte_bus_i,
  output logic      [7:0] fifo_byte_bus_o,
  output logic            fifo_byte_bus_oe_o,
  input  wire logic       rx_data_avail_n_i,
  output logic            rx_data_avail_n_o,
  output logic            rx_data_avail_n_oe_o,
  output logic            tx_space_avail_n_o,
  output logic            tx_space_avail_n_oe_o,
  output logic            power_enable_n_o,
  output logic            pull_down_o,
  output logic            pull_up_o,
  // USB engine side
  input  wire logic       usb_configured_i,
  input  wire logic       usb_suspend_i,
  input  wire logic       remote_wake_en_i,
  input  wire logic       suspend_pulldown_en_i,
  input  wire logic       rx_push_i,
  input  wire logic [7:0] rx_push_data_i,
  output logic            rx_push_ready_o,
  output logic            tx_pop_valid_o,
  output logic      [7:0] tx_pop_data_o,
  input  wire logic       tx_pop_i,
  output logic            resume_req_o
);
  // ==========================================================
  // Declarations
  logic [7:0]              rx_mem [ufp_pkg::DEPTH];
  logic [7:0]              tx_mem [ufp_pkg::DEPTH];
  logic [8:0]              rx_wp_r;
  logic [8:0]              rx_rp_r;
  logic [9:0]              rx_cnt_r;
  logic [8:0]              tx_wp_r;
  logic [8:0]              tx_rp_r;
  logic [9:0]              tx_cnt_r;
  logic [7:0]              rd_byte_r;
  logic [7:0]              tx_pop_data_r;
  logic [10:0]             pins_s;
  logic                    rd_n_s;
  logic                    wr_s;
  logic [7:0]              bus_s;
  logic                    rxf_in_s;
  logic                    rd_n_d_r;
  logic                    wr_d_r;
  logic                    rd_fall;
  logic                    wr_fall;
  logic                    rx_pop;
  logic                    tx_push;
  logic                    wake_mode;
  logic                    pwr_n_r;
  ufp_pkg::ufp_wake_t      wake_r;
  logic [19:0]             wake_cnt_r;

  // Wrapping 9-bit increment for the circular pointers
  function automatic logic [8:0] ufp_inc(input logic [8:0] p);
    return p + 9'h001;
  endfunction

  // ==========================================================
  // Pin synchronisers; strobes idle inactive (rd high, wr low)
  ufp_sync #(.W(11), .INIT(11'h401)) u_sync
  (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .async_i ({rd_n_i, wr_i, fifo_byte_bus_i, rx_data_avail_n_i}),
    .sync_o  (pins_s)
  );
  // Bus is synced with the strobe, so data must settle before wr falls
  assign rd_n_s   = pins_s[10];
  assign wr_s     = pins_s[9];
  assign bus_s    = pins_s[8:1];
  assign rxf_in_s = pins_s[0];

  // ==========================================================
  // Strobe edge detection
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      rd_n_d_r <= 1'b1;
      wr_d_r   <= 1'b0;
    end
    else
    begin
      rd_n_d_r <= rd_n_s;
      wr_d_r   <= wr_s;
    end
  end
  assign rd_fall = rd_n_d_r & ~rd_n_s;
  assign wr_fall = wr_d_r & ~wr_s;
  // Pop only when a byte exists; otherwise state is left alone
  assign rx_pop  = rd_fall & (rx_cnt_r != ufp_pkg::CNT_RST);
  assign tx_push = wr_fall & (tx_cnt_r != 10'(ufp_pkg::DEPTH));
  assign rx_push_ready_o = (rx_cnt_r != 10'(ufp_pkg::DEPTH));
  assign tx_pop_valid_o  = (tx_cnt_r != ufp_pkg::CNT_RST);

  // ==========================================================
  // Receive buffer: engine writes, host strobe reads
  always_ff @(posedge clock_i)
  begin
    if (rx_push_i && rx_push_ready_o)
      rx_mem[rx_wp_r] <= rx_push_data_i;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      rx_wp_r   <= ufp_pkg::PTR_RST;
      rx_rp_r   <= ufp_pkg::PTR_RST;
      rx_cnt_r  <= ufp_pkg::CNT_RST;
      rd_byte_r <= ufp_pkg::BYTE_RST;
    end
    else
    begin
      if (rx_push_i && rx_push_ready_o)
        rx_wp_r <= ufp_inc(rx_wp_r);
      if (rx_pop)
      begin
        rx_rp_r   <= ufp_inc(rx_rp_r);
        rd_byte_r <= rx_mem[rx_rp_r];
      end
      rx_cnt_r <= rx_cnt_r + 10'((rx_push_i && rx_push_ready_o) ? 1 : 0)
                           - 10'(rx_pop ? 1 : 0);
    end
  end

  // ==========================================================
  // Transmit buffer: host strobe writes, engine reads
  always_ff @(posedge clock_i)
  begin
    if (tx_push)
      tx_mem[tx_wp_r] <= bus_s;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      tx_wp_r       <= ufp_pkg::PTR_RST;
      tx_rp_r       <= ufp_pkg::PTR_RST;
      tx_cnt_r      <= ufp_pkg::CNT_RST;
      tx_pop_data_r <= ufp_pkg::BYTE_RST;
    end
    else
    begin
      if (tx_push)
        tx_wp_r <= ufp_inc(tx_wp_r);
      if (tx_pop_i && tx_pop_valid_o)
      begin
        tx_rp_r       <= ufp_inc(tx_rp_r);
        tx_pop_data_r <= tx_mem[tx_rp_r];
      end
      tx_cnt_r <= tx_cnt_r + 10'(tx_push ? 1 : 0)
                           - 10'((tx_pop_i && tx_pop_valid_o) ? 1 : 0);
    end
  end
  assign tx_pop_data_o = tx_pop_data_r;

  // ==========================================================
  // Data bus drive: only while read strobe is low
  assign fifo_byte_bus_o    = rd_byte_r;
  assign fifo_byte_bus_oe_o = rstn_i & ~rd_n_s & ~rd_n_d_r;

  // ==========================================================
  // Status flags; both released while in reset, the rx flag also in wake input mode
  assign wake_mode             = remote_wake_en_i & pwr_n_r;
  assign rx_data_avail_n_o     = (rx_cnt_r == ufp_pkg::CNT_RST);
  assign rx_data_avail_n_oe_o  = rstn_i & ~wake_mode;
  assign tx_space_avail_n_o    = (tx_cnt_r == 10'(ufp_pkg::DEPTH));
  assign tx_space_avail_n_oe_o = rstn_i;

  // ==========================================================
  // Power enable indication and suspend pulls
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
      pwr_n_r <= 1'b1;
    else if (usb_suspend_i)
      pwr_n_r <= 1'b1;
    else if (usb_configured_i)
      pwr_n_r <= 1'b0;
  end
  assign power_enable_n_o = pwr_n_r;
  assign pull_down_o      = pwr_n_r & suspend_pulldown_en_i;
  assign pull_up_o        = ~pull_down_o;

  // ==========================================================
  // Wake detector: low held for the full interval raises resume
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      wake_r     <= ufp_pkg::UFP_W_IDLE;
      wake_cnt_r <= ufp_pkg::WAKE_RST;
    end
    else if (!wake_mode || rxf_in_s)
    begin
      wake_r     <= ufp_pkg::UFP_W_IDLE;
      wake_cnt_r <= ufp_pkg::WAKE_RST;
    end
    else
    begin
      case (wake_r)
        ufp_pkg::UFP_W_IDLE:
        begin
          wake_r     <= ufp_pkg::UFP_W_COUNT;
          wake_cnt_r <= 20'h00001;
        end
        ufp_pkg::UFP_W_COUNT:
        begin
          if (wake_cnt_r == 20'(ufp_pkg::WAKE_CYCLES))
            wake_r <= ufp_pkg::UFP_W_DONE;
          else
            wake_cnt_r <= wake_cnt_r + 20'h00001;
        end
        ufp_pkg::UFP_W_DONE:
          wake_r <= ufp_pkg::UFP_W_DONE;
        default:
          wake_r <= ufp_pkg::UFP_W_IDLE;
      endcase
    end
  end
  assign resume_req_o = (wake_r == ufp_pkg::UFP_W_DONE);

  // ==========================================================
  // Checks
  sequence s_rd_fall_avail;
    rd_fall && rx_cnt_r != 10'h000;
  endsequence

  a_bus_drive_rd: assert property (@(posedge clock_i) disable iff (!rstn_i)
    fifo_byte_bus_oe_o |-> !rd_n_s) else $error("bus driven with read high");
  a_rd_advance: assert property (@(posedge clock_i) disable iff (!rstn_i)
    s_rd_fall_avail ##0 !rx_push_i |=> rx_cnt_r == $past(rx_cnt_r) - 10'h001)
    else $error("read fall did not advance");
  a_rd_empty_hold: assert property (@(posedge clock_i) disable iff (!rstn_i)
    rd_fall && rx_cnt_r == 10'h000 |=> $stable(rx_rp_r))
    else $error("empty read moved pointer");
  a_wr_capture: assert property (@(posedge clock_i) disable iff (!rstn_i)
    wr_fall && !tx_space_avail_n_o && !tx_pop_i |=> tx_cnt_r == $past(tx_cnt_r) + 10'h001)
    else $error("write fall not captured");
  a_rxf_level: assert property (@(posedge clock_i) disable iff (!rstn_i)
    rx_data_avail_n_o == (rx_cnt_r == 10'h000)) else $error("rx flag wrong");
  a_flags_reset: assert property (@(posedge clock_i)
    !rstn_i |-> !tx_space_avail_n_oe_o && !rx_data_avail_n_oe_o)
    else $error("flags driven in reset");
  a_wake_input: assert property (@(posedge clock_i) disable iff (!rstn_i)
    remote_wake_en_i && pwr_n_r |-> !rx_data_avail_n_oe_o)
    else $error("rx flag driven in wake mode");
  a_wake_resume: assert property (@(posedge clock_i) disable iff (!rstn_i)
    wake_r == ufp_pkg::UFP_W_COUNT && wake_cnt_r == 20'(ufp_pkg::WAKE_CYCLES)
    && wake_mode && !rxf_in_s |=> resume_req_o) else $error("resume missing");
  a_pwr_suspend: assert property (@(posedge clock_i) disable iff (!rstn_i)
    usb_suspend_i |=> power_enable_n_o) else $error("power enable low in suspend");
  a_pull_down: assert property (@(posedge clock_i) disable iff (!rstn_i)
    pull_down_o |-> power_enable_n_o && suspend_pulldown_en_i)
    else $error("pull down outside suspend");
endmodule // ufp_port
`default_nettype wire

// file: ufp_sync.sv
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes inputs are asynchronous to clock_i.
`timescale 1ns/1ps
`default_nettype none
module ufp_sync
#(
  parameter int W     = 1,
  parameter logic [W-1:0] INIT = '0
)
(
  // Clock and reset
  input  wire logic         clock_i,
  input  wire logic         rstn_i,
  // Data
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_r;

  // ==========================================================
  // Synchroniser flops; first stage feeds only the second
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      meta_r <= INIT;
      sync_o <= INIT;
    end
    else
    begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule // ufp_sync
`default_nettype wire
